//--- shared/config_prom_pkg.sv
// Constants, types and encodings of the serial configuration memory sequencer.
// Assumes one core clock of 20 MHz; every pin arrives asynchronously.
package config_prom_pkg;

  // Core clock period and derived timing counts
  localparam int unsigned CORE_CLK_PERIOD_NS = 50;
  localparam int unsigned RESET_HOLD_NS      = 1000;
  localparam int unsigned CF_PULSE_NS        = 2000;
  // Least times round up to whole cycles
  localparam int unsigned RESET_HOLD_CYC     = (RESET_HOLD_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;
  localparam int unsigned CF_PULSE_CYC       = (CF_PULSE_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;
  localparam int unsigned CNT_W              = 8;

  // Storage geometry: one megabit of serial configuration data
  localparam int unsigned ADDR_W             = 20;
  localparam int unsigned MEM_DEPTH          = 1 << ADDR_W;
  localparam logic [ADDR_W-1:0] TERMINAL_COUNT = 20'hfffff;
  localparam logic [ADDR_W-1:0] ADDR_RESET     = 20'h00000;

  // Boundary-scan register layout
  localparam int unsigned BSR_LEN            = 23;
  localparam int unsigned BSR_CFG_CLK        = 0;
  localparam int unsigned BSR_DOUT_OE        = 3;
  localparam int unsigned BSR_DOUT_DATA      = 4;
  localparam int unsigned BSR_CEO_OE         = 11;
  localparam int unsigned BSR_CEO_DATA       = 12;
  localparam int unsigned BSR_CE_IN          = 15;
  localparam int unsigned BSR_OERST_OE       = 18;
  localparam int unsigned BSR_OERST_DATA     = 19;
  localparam int unsigned BSR_OERST_IN       = 20;
  localparam int unsigned BSR_CF_OE          = 21;
  localparam int unsigned BSR_CF_DATA        = 22;

  // Instruction register; opcode values are arbitrary
  localparam int unsigned IR_W               = 8;
  localparam logic [IR_W-1:0] IR_CAPTURE     = 8'h01;
  localparam logic [IR_W-1:0] OP_EXTEST      = 8'h00;
  localparam logic [IR_W-1:0] OP_SAMPLE      = 8'h01;
  localparam logic [IR_W-1:0] OP_CLAMP       = 8'hfa;
  localparam logic [IR_W-1:0] OP_RECONFIG    = 8'hee;
  localparam logic [IR_W-1:0] OP_ISP_ENTER   = 8'he8;
  localparam logic [IR_W-1:0] OP_ISP_WRITE   = 8'hea;
  localparam logic [IR_W-1:0] OP_ISP_LEAVE   = 8'hf0;
  localparam logic [IR_W-1:0] OP_BYPASS      = 8'hff;

  // TAP controller states, one-hot
  typedef enum logic [15:0] {
    TAP_RESET  = 16'h0001, TAP_IDLE   = 16'h0002, TAP_SEL_DR = 16'h0004, TAP_CAP_DR = 16'h0008,
    TAP_SH_DR  = 16'h0010, TAP_EX1_DR = 16'h0020, TAP_PA_DR  = 16'h0040, TAP_EX2_DR = 16'h0080,
    TAP_UPD_DR = 16'h0100, TAP_SEL_IR = 16'h0200, TAP_CAP_IR = 16'h0400, TAP_SH_IR  = 16'h0800,
    TAP_EX1_IR = 16'h1000, TAP_PA_IR  = 16'h2000, TAP_EX2_IR = 16'h4000, TAP_UPD_IR = 16'h8000
  } tap_state_t;

  // Asynchronous pin inputs, carried together through the synchroniser
  typedef struct packed {
    logic cfg_clk;
    logic cfg_clk_sel;
    logic chip_enable_n;
    logic oe_reset_n;
    logic tck;
    logic tms;
    logic tdi;
  } pin_in_t;

  localparam pin_in_t PINS_RESET = '{cfg_clk: 1'b0, cfg_clk_sel: 1'b0, chip_enable_n: 1'b1,
                                     oe_reset_n: 1'b0, tck: 1'b0, tms: 1'b1, tdi: 1'b1};

endpackage : config_prom_pkg

//--- hdl/config_store.sv
// Bit-wide configuration storage with one write port and a registered read.
// Assumes writes come only from the in-system programming path.
`timescale 1ns/10ps
module config_store
  import config_prom_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire logic              reset_i,
  input  wire logic              wr_en_i,
  input  wire logic [ADDR_W-1:0] wr_addr_i,
  input  wire logic              wr_bit_i,
  input  wire logic [ADDR_W-1:0] rd_addr_i,
  output logic                   rd_bit_o
);

  typedef struct packed {
    logic rd_bit;
  } store_state_t;

  store_state_t state_q;
  store_state_t state_d;
  logic         mem [0:MEM_DEPTH-1];  // Erased contents are undefined until programmed

  // Read follows the address one clock later
  always_comb
  begin
    state_d        = state_q;
    state_d.rd_bit = mem[rd_addr_i];
  end

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
      state_q <= '0;
    else
      state_q <= state_d;
  end

  // Memory array kept apart from reset: a real flash keeps its contents
  always_ff @(posedge core_clk_i)
  begin
    if (wr_en_i)
      mem[wr_addr_i] <= wr_bit_i;
  end

  assign rd_bit_o = state_q.rd_bit;

endmodule : config_store

//--- hdl/config_prom_sequencer.sv
// Sequencer of a serial configuration memory: address counter, serial data
// output, cascade hand-over, reset pin handling and a small JTAG port.
// Assumes every pin input is asynchronous to core_clk_i and much slower than it.
`timescale 1ns/10ps
module config_prom_sequencer
  import config_prom_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic reset_i,
  input  wire logic config_clk_i,
  input  wire logic config_clk_sel_i,
  input  wire logic chip_enable_n_i,
  input  wire logic oe_reset_n_i,
  output logic      oe_reset_n_o,
  output logic      oe_reset_n_oe_o,
  output logic      serial_data_out_o,
  output logic      serial_data_out_oe_o,
  output logic      cascade_enable_out_n_o,
  output logic      config_pulse_n_o,
  output logic      config_pulse_n_oe_o,
  output logic      standby_o,
  output logic      in_system_program_mode_o,
  input  wire logic tck_i,
  input  wire logic tms_i,
  input  wire logic tdi_i,
  output logic      tdo_o,
  output logic      tdo_oe_o
);

  typedef struct packed {
    pin_in_t              sync1;
    pin_in_t              sync2;
    logic                 cfg_clk_d;
    logic                 tck_d;
    logic [CNT_W-1:0]     hold_cnt;
    logic [ADDR_W-1:0]    addr;
    logic                 past_tc;
    logic                 ceo_n;
    logic                 dout_oe;
    logic                 dout_bsr;
    tap_state_t           tap;
    logic [IR_W-1:0]      ir_sh;
    logic [IR_W-1:0]      ir;
    logic [BSR_LEN-1:0]   bsr_sh;
    logic [BSR_LEN-1:0]   bsr_upd;
    logic                 bypass;
    logic                 prog_bit;
    logic [ADDR_W-1:0]    prog_addr;
    logic                 isp_mode;
    logic                 tdo;
    logic                 tdo_oe;
    logic [CNT_W-1:0]     cf_cnt;
  } seq_state_t;

  seq_state_t state_q;
  seq_state_t state_d;
  logic       store_bit;
  logic       wr_en;

  // TAP next state from the sampled mode select
  function automatic tap_state_t tap_next(input tap_state_t s, input logic tms);
    case (s)
      TAP_RESET:  tap_next = tms ? TAP_RESET  : TAP_IDLE;
      TAP_IDLE:   tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: tap_next = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:  tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: tap_next = tms ? TAP_UPD_DR : TAP_PA_DR;
      TAP_PA_DR:  tap_next = tms ? TAP_EX2_DR : TAP_PA_DR;
      TAP_EX2_DR: tap_next = tms ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: tap_next = tms ? TAP_RESET  : TAP_CAP_IR;
      TAP_CAP_IR: tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:  tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: tap_next = tms ? TAP_UPD_IR : TAP_PA_IR;
      TAP_PA_IR:  tap_next = tms ? TAP_EX2_IR : TAP_PA_IR;
      TAP_EX2_IR: tap_next = tms ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
      default:    tap_next = TAP_RESET;
    endcase
  endfunction : tap_next

  // Instructions that route the scan register to the serial data output and its enable
  function automatic logic drives_from_bsr(input logic [IR_W-1:0] op);
    drives_from_bsr = (op == OP_EXTEST) || (op == OP_CLAMP);
  endfunction : drives_from_bsr

  // Instructions that select the scan register between TDI and TDO
  function automatic logic uses_bsr(input logic [IR_W-1:0] op);
    uses_bsr = (op == OP_EXTEST) || (op == OP_SAMPLE);
  endfunction : uses_bsr

  // Shared conditions, from synchronised pins, reset_i and the reset stretch
  logic in_reset;
  logic enabled;
  logic cfg_rise;
  logic tck_rise;
  logic tck_fall;

  assign in_reset = reset_i || (state_q.hold_cnt != '0);
  assign enabled  = !state_q.sync2.chip_enable_n && state_q.sync2.oe_reset_n && !in_reset;
  assign cfg_rise = state_q.sync2.cfg_clk && !state_q.cfg_clk_d;
  assign tck_rise = state_q.sync2.tck && !state_q.tck_d;
  assign tck_fall = !state_q.sync2.tck && state_q.tck_d;

  // Program write fires on Update-DR while the write instruction is loaded in programming mode
  assign wr_en = tck_rise && (state_q.tap == TAP_UPD_DR) && (state_q.ir == OP_ISP_WRITE) && state_q.isp_mode;

  always_comb
  begin
    state_d = state_q;

    // Two-stage synchroniser; only stage two is ever decoded
    state_d.sync1.cfg_clk       = config_clk_i;
    state_d.sync1.cfg_clk_sel   = config_clk_sel_i;
    state_d.sync1.chip_enable_n = chip_enable_n_i;
    state_d.sync1.oe_reset_n    = oe_reset_n_i;
    state_d.sync1.tck           = tck_i;
    state_d.sync1.tms           = tms_i;
    state_d.sync1.tdi           = tdi_i;
    state_d.sync2               = state_q.sync1;
    state_d.cfg_clk_d           = state_q.sync2.cfg_clk;
    state_d.tck_d               = state_q.sync2.tck;

    // Internal reset stretch while the pin is held low
    if (state_q.hold_cnt != '0)
      state_d.hold_cnt = state_q.hold_cnt - 1'b1;

    // Address counter and terminal-count tracking
    if (!enabled)
    begin
      state_d.addr    = ADDR_RESET;
      state_d.past_tc = 1'b0;
    end
    else if (cfg_rise && state_q.sync2.cfg_clk_sel)
    begin
      state_d.addr = state_q.addr + 1'b1;
      if (state_q.addr == TERMINAL_COUNT)
        state_d.past_tc = 1'b1;
    end

    // Cascade hand-over; disable drops it on the very next edge
    state_d.ceo_n = !(enabled && state_q.past_tc);

    // Serial output enable; programming mode floats it unless EXTEST or CLAMP drives it from the scan register
    state_d.dout_oe  = enabled && !state_q.isp_mode;
    state_d.dout_bsr = drives_from_bsr(state_q.ir);

    // Reconfigure pulse timer
    if (state_q.cf_cnt != '0)
      state_d.cf_cnt = state_q.cf_cnt - 1'b1;

    // TAP walk on each TCK rise
    if (tck_rise)
    begin
      state_d.tap = tap_next(state_q.tap, state_q.sync2.tms);
      case (state_q.tap)
        TAP_RESET:
        begin
          state_d.ir       = OP_BYPASS;
          state_d.isp_mode = 1'b0;
        end
        TAP_CAP_IR:
          state_d.ir_sh = IR_CAPTURE;
        TAP_SH_IR:
          state_d.ir_sh = {state_q.sync2.tdi, state_q.ir_sh[IR_W-1:1]};
        TAP_UPD_IR:
        begin
          state_d.ir = state_q.ir_sh;
          if (state_q.ir_sh == OP_RECONFIG)
            state_d.cf_cnt = CNT_W'(CF_PULSE_CYC);
          if (state_q.ir_sh == OP_ISP_ENTER)
          begin
            state_d.isp_mode  = 1'b1;
            state_d.prog_addr = ADDR_RESET;
          end
          if (state_q.ir_sh == OP_ISP_LEAVE)
            state_d.isp_mode = 1'b0;
        end
        TAP_CAP_DR:
        begin
          // Pin states into their scan cells
          state_d.bsr_sh                 = '0;
          state_d.bsr_sh[BSR_CFG_CLK]    = state_q.sync2.cfg_clk;
          state_d.bsr_sh[BSR_DOUT_DATA]  = store_bit;
          state_d.bsr_sh[BSR_DOUT_OE]    = serial_data_out_oe_o;
          state_d.bsr_sh[BSR_CEO_DATA]   = state_q.ceo_n;
          state_d.bsr_sh[BSR_CEO_OE]     = 1'b1;
          state_d.bsr_sh[BSR_CE_IN]      = state_q.sync2.chip_enable_n;
          state_d.bsr_sh[BSR_OERST_DATA] = 1'b0;
          state_d.bsr_sh[BSR_OERST_OE]   = oe_reset_n_oe_o;
          state_d.bsr_sh[BSR_OERST_IN]   = state_q.sync2.oe_reset_n;
          state_d.bsr_sh[BSR_CF_DATA]    = 1'b0;
          state_d.bsr_sh[BSR_CF_OE]      = config_pulse_n_oe_o;
          state_d.bypass                 = 1'b0;
          state_d.prog_bit               = 1'b0;
        end
        TAP_SH_DR:
        begin
          if (uses_bsr(state_q.ir))
            state_d.bsr_sh = {state_q.sync2.tdi, state_q.bsr_sh[BSR_LEN-1:1]};
          else if (state_q.ir == OP_ISP_WRITE)
            state_d.prog_bit = state_q.sync2.tdi;
          else
            state_d.bypass = state_q.sync2.tdi;
        end
        TAP_UPD_DR:
        begin
          if (uses_bsr(state_q.ir))
            state_d.bsr_upd = state_q.bsr_sh;
          if (wr_en)
            state_d.prog_addr = state_q.prog_addr + 1'b1;
        end
        default:
          state_d.tap = tap_next(state_q.tap, state_q.sync2.tms);
      endcase
    end

    // TDO changes on the falling TCK edge, driven only while shifting
    if (tck_fall)
    begin
      state_d.tdo_oe = (state_q.tap == TAP_SH_DR) || (state_q.tap == TAP_SH_IR);
      if (state_q.tap == TAP_SH_IR)
        state_d.tdo = state_q.ir_sh[0];
      else if (uses_bsr(state_q.ir))
        state_d.tdo = state_q.bsr_sh[0];
      else if (state_q.ir == OP_ISP_WRITE)
        state_d.tdo = state_q.prog_bit;
      else
        state_d.tdo = state_q.bypass;
    end
  end

  // Synchronous reset; the reset pin is then held low for a fixed stretch
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      state_q           <= '0;
      state_q.sync1     <= PINS_RESET;
      state_q.sync2     <= PINS_RESET;
      state_q.hold_cnt  <= CNT_W'(RESET_HOLD_CYC);
      state_q.ceo_n     <= 1'b1;
      state_q.tap       <= TAP_RESET;
      state_q.ir        <= OP_BYPASS;
      state_q.tdo       <= 1'b1;
    end
    else
      state_q <= state_d;
  end

  // Storage for the configuration stream
  config_store u_store (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .wr_en_i    (wr_en),
    .wr_addr_i  (state_q.prog_addr),
    .wr_bit_i   (state_q.prog_bit),
    .rd_addr_i  (state_q.addr),
    .rd_bit_o   (store_bit)
  );

  // Pin drivers; open-drain pins only ever drive low
  assign oe_reset_n_o             = 1'b0;
  assign oe_reset_n_oe_o          = in_reset;
  assign serial_data_out_o        = state_q.dout_bsr ? state_q.bsr_upd[BSR_DOUT_DATA]
                                                     : store_bit;
  assign serial_data_out_oe_o     = state_q.dout_bsr ? state_q.bsr_upd[BSR_DOUT_OE]
                                                     : state_q.dout_oe;
  assign cascade_enable_out_n_o   = state_q.ceo_n;
  assign config_pulse_n_o         = 1'b0;
  assign config_pulse_n_oe_o      = (state_q.cf_cnt != '0);
  assign standby_o                = state_q.sync2.chip_enable_n;
  assign in_system_program_mode_o = state_q.isp_mode;
  assign tdo_o                    = state_q.tdo;
  assign tdo_oe_o                 = state_q.tdo_oe;

endmodule : config_prom_sequencer

//--- test/config_prom_sequencer_asserts.sv
// Checker of the serial configuration memory sequencer, bound to its ports.
// Assumes pins are held several core cycles so the synchroniser settles.
`timescale 1ns/10ps
module config_prom_sequencer_asserts
  import config_prom_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic config_clk_i,
  input wire logic chip_enable_n_i,
  input wire logic oe_reset_n_i,
  input wire logic oe_reset_n_o,
  input wire logic oe_reset_n_oe_o,
  input wire logic serial_data_out_o,
  input wire logic serial_data_out_oe_o,
  input wire logic cascade_enable_out_n_o,
  input wire logic config_pulse_n_oe_o,
  input wire logic standby_o,
  input wire logic in_system_program_mode_o,
  input wire logic tck_i,
  input wire logic tdo_o
);
  int unsigned cf_len_q;

  // Cycles the reconfigure pulse has stood so far
  always_ff @(posedge core_clk_i)
    cf_len_q <= (reset_i || !config_pulse_n_oe_o) ? 0 : cf_len_q + 1;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);

  // Pins pass two sync flops, so five samples settle any level
  sequence s_ce_off; chip_enable_n_i [*5]; endsequence
  sequence s_off; (chip_enable_n_i || !oe_reset_n_i) [*5]; endsequence
  sequence s_live; serial_data_out_oe_o && $past(serial_data_out_oe_o, 3); endsequence
  sequence s_kept; !$past(chip_enable_n_i, 2) && $past(oe_reset_n_i, 2); endsequence

  property p_hold; $fell(reset_i) |-> oe_reset_n_oe_o [*8]; endproperty
  a_hold: assert property (p_hold) else $error("reset pin let go early");
  property p_od; oe_reset_n_oe_o |-> !oe_reset_n_o; endproperty
  a_od: assert property (p_od) else $error("reset pin driven high");
  property p_pin_hiz; !oe_reset_n_i [*5] |-> !serial_data_out_oe_o; endproperty
  a_pin_hiz: assert property (p_pin_hiz) else $error("data driven with pin low");
  property p_ce_hiz; s_ce_off |-> standby_o && !serial_data_out_oe_o; endproperty
  a_ce_hiz: assert property (p_ce_hiz) else $error("not in standby");
  property p_ceo_high; s_off |-> cascade_enable_out_n_o; endproperty
  a_ceo_high: assert property (p_ceo_high) else $error("hand-over stuck low");
  property p_ceo_low; !cascade_enable_out_n_o |-> !$past(chip_enable_n_i, 4) && $past(oe_reset_n_i, 4); endproperty
  a_ceo_low: assert property (p_ceo_low) else $error("hand-over while disabled");
  property p_cf_len; $fell(config_pulse_n_oe_o) |-> cf_len_q == CF_PULSE_CYC; endproperty
  a_cf_len: assert property (p_cf_len) else $error("pulse length wrong");
  property p_isp_hiz; in_system_program_mode_o [*3] |-> !serial_data_out_oe_o; endproperty
  a_isp_hiz: assert property (p_isp_hiz) else $error("data driven while programming");
  property p_tdo_fall; $changed(tdo_o) |-> !tck_i; endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("test output moved with clock high");
  property p_adv; $changed(serial_data_out_o) ##0 s_live ##0 s_kept |-> $past(config_clk_i, 3); endproperty
  a_adv: assert property (p_adv) else $error("data moved without clock");
endmodule : config_prom_sequencer_asserts

bind config_prom_sequencer config_prom_sequencer_asserts u_chk (
  .core_clk_i(core_clk_i), .reset_i(reset_i), .config_clk_i(config_clk_i), .chip_enable_n_i(chip_enable_n_i),
  .oe_reset_n_i(oe_reset_n_i), .oe_reset_n_o(oe_reset_n_o), .oe_reset_n_oe_o(oe_reset_n_oe_o),
  .serial_data_out_o(serial_data_out_o), .serial_data_out_oe_o(serial_data_out_oe_o),
  .cascade_enable_out_n_o(cascade_enable_out_n_o), .config_pulse_n_oe_o(config_pulse_n_oe_o),
  .standby_o(standby_o), .in_system_program_mode_o(in_system_program_mode_o), .tck_i(tck_i), .tdo_o(tdo_o));

//--- test/fpga_cfg_model.sv
// Far-side model: configuration port of the FPGA being loaded.
// Assumes the bench calls pulse_bits from a core clock edge.
`timescale 1ns/10ps
module fpga_cfg_model (
  input  wire logic clk_i,
  input  wire logic dout_i,
  input  wire logic dout_oe_i,
  output logic      cfg_clk_o
);
  logic last_q = 1'b0;
  logic got[$];
  logic line;

  // Data line has no pull, so a released line shows the inverse level
  always @(posedge clk_i)
    if (dout_oe_i === 1'b1)
      last_q <= dout_i;
  assign line = (dout_oe_i === 1'b1) ? dout_i : ~last_q;

  // One rise per bit, sampled just before it; clock idles low between frames
  task automatic pulse_bits(input int n);
    for (int i = 0; i < n; i++)
    begin
      repeat (4) @(posedge clk_i);
      @(negedge clk_i) got.push_back(line);
      @(posedge clk_i) cfg_clk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      cfg_clk_o <= 1'b0;
    end
  endtask : pulse_bits

  initial
    cfg_clk_o = 1'b0;
endmodule : fpga_cfg_model

//--- test/testbench.sv
// Self-checking bench of the serial configuration memory sequencer.
// Assumes the FPGA model makes the configuration clock; bench drives JTAG.
`timescale 1ns/10ps
module testbench;
  import config_prom_pkg::*;
  localparam int NB = 16;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sel = 1'b1;
  logic ce_n = 1'b0;
  logic ext_pull = 1'b0;
  logic tck = 1'b0;
  logic tms = 1'b1;
  logic tdi = 1'b1;
  logic oe_pin, oe_rst_oe, dout, dout_oe, ceo_n, cf_oe, stby, isp, tdo, cfg_clk, next_ce_n, t;
  logic [31:0] o;
  logic mem [int];
  int seed = 32'haf64e329;
  int err_total = 0;
  int n_tests = 0;
  int addr = 0;
  int pw = 0;
  int run = 0;

  config_prom_sequencer dut (
    .core_clk_i(clk), .reset_i(rst), .config_clk_i(cfg_clk), .config_clk_sel_i(sel), .chip_enable_n_i(ce_n),
    .oe_reset_n_i(oe_pin), .oe_reset_n_o(), .oe_reset_n_oe_o(oe_rst_oe), .serial_data_out_o(dout),
    .serial_data_out_oe_o(dout_oe), .cascade_enable_out_n_o(ceo_n), .config_pulse_n_o(),
    .config_pulse_n_oe_o(cf_oe), .standby_o(stby), .in_system_program_mode_o(isp),
    .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o());
  fpga_cfg_model u_fpga (.clk_i(clk), .dout_i(dout), .dout_oe_i(dout_oe), .cfg_clk_o(cfg_clk));

  // Open-drain pin with pull-up; cascade feeds the next memory
  assign oe_pin = ~(oe_rst_oe | ext_pull);
  assign next_ce_n = ceo_n;

  always #25 clk = ~clk;

  // Width of the latest reconfigure pulse
  always @(posedge clk)
  begin
    run <= cf_oe ? run + 1 : 0;
    if (!cf_oe && run != 0)
      pw <= run;
  end

  task automatic chk1(input logic g, input logic e, input string m);
    n_tests++;
    if (g !== e)
    begin
      err_total++;
      $display("Error %0t: %s got %b want %b", $time, m, g, e);
    end
  endtask : chk1

  task automatic chkv(input logic [31:0] g, input logic [31:0] e, input string m);
    n_tests++;
    if (g !== e)
    begin
      err_total++;
      $display("Error %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask : chkv

  // One TCK period, test output sampled just before the rise
  task automatic jt(input logic ms, input logic di, output logic so);
    @(posedge clk) tms <= ms;
    tdi <= di;
    repeat (5) @(posedge clk);
    @(negedge clk) so = tdo;
    @(posedge clk) tck <= 1'b1;
    repeat (4) @(posedge clk);
    tck <= 1'b0;
  endtask : jt

  // From idle through capture, shift of n bits, update, back to idle
  task automatic scan(input bit ir, input int n, input logic [31:0] v, output logic [31:0] so);
    so = '0;
    jt(1'b1, 1'b0, t);
    if (ir)
      jt(1'b1, 1'b0, t);
    jt(1'b0, 1'b0, t);
    jt(1'b0, 1'b0, t);
    for (int i = 0; i < n; i++)
      jt(i == n - 1, v[i], so[i]);
    jt(1'b1, 1'b0, t);
    jt(1'b0, 1'b0, t);
  endtask : scan

  task automatic ir(input logic [7:0] op);
    scan(1'b1, 8, {24'h0, op}, o);
    chkv({24'h0, o[7:0]}, {24'h0, IR_CAPTURE}, "instruction capture");
  endtask : ir

  task automatic stream(input int n);
    repeat (8) @(posedge clk);
    u_fpga.got.delete();
    u_fpga.pulse_bits(n);
    for (int k = 0; k < n; k++)
    begin
      chk1(u_fpga.got[k], mem[addr], "stream bit");
      if (sel)
        addr++;
    end
  endtask : stream

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  // Main sequence
  initial
  begin
    repeat (2) @(posedge clk);
    @(negedge clk) chk1(oe_rst_oe, 1'b1, "pin pulled in reset");
    @(posedge clk) rst <= 1'b0;
    repeat (15) @(posedge clk);
    @(negedge clk) chk1(oe_rst_oe, 1'b1, "reset stretch");
    chk1(dout_oe, 1'b0, "data off with pin low");
    repeat (20) @(posedge clk);
    @(negedge clk) chk1(oe_rst_oe, 1'b0, "pin released");
    chk1(dout_oe, 1'b1, "data driven");
    $display("Test reset done");
    jt(1'b0, 1'b0, t);
    ir(OP_ISP_ENTER);
    // Output enable is registered a cycle after the mode flag, so look half a cycle on
    @(negedge clk) chk1(isp, 1'b1, "programming mode");
    chk1(dout_oe, 1'b0, "data off while programming");
    ir(OP_ISP_WRITE);
    for (int k = 0; k < NB; k++)
    begin
      mem[k] = 1'($random(seed));
      scan(1'b0, 1, {31'h0, mem[k]}, o);
    end
    ir(OP_ISP_LEAVE);
    @(negedge clk) chk1(isp, 1'b0, "programming left");
    $display("Test program done");
    stream(8);
    sel <= 1'b0;
    stream(3);
    sel <= 1'b1;
    chk1(next_ce_n, 1'b1, "no hand-over before terminal");
    $display("Test stream done");
    ir(OP_SAMPLE);
    for (int v = 1; v >= 0; v--)
    begin
      ce_n <= v[0];
      addr = 0;
      repeat (8) @(posedge clk);
      @(negedge clk) chk1(stby, v[0], "standby");
      chk1(dout_oe, ~v[0], "data enable");
      chk1(ceo_n, 1'b1, "hand-over off");
      scan(1'b0, 23, 32'h0, o);
      chk1(o[15], v[0], "scan enable cell");
      chk1(o[3], ~v[0], "scan output enable cell");
    end
    chk1(o[4], mem[0], "scan data cell");
    stream(NB);
    ext_pull <= 1'b1;
    repeat (8) @(posedge clk);
    @(negedge clk) chk1(dout_oe, 1'b0, "data off on pin low");
    @(posedge clk) ext_pull <= 1'b0;
    addr = 0;
    stream(4);
    $display("Test enable done");
    ir(OP_EXTEST);
    // Data cell then enable cell; ends with enable off so leaving the mode is quiet
    for (int v = 0; v < 3; v++)
    begin
      scan(1'b0, 23, {27'h0, v != 2, v == 1, 3'h0}, o);
      @(negedge clk) chk1(dout_oe, v == 1, "scan drives enable");
      chk1(dout, v != 2, "scan drives data");
    end
    ir(OP_BYPASS);
    scan(1'b0, 2, 32'h1, o);
    chkv({30'h0, o[1:0]}, 32'h2, "bypass path");
    $display("Test scan done");
    ir(OP_RECONFIG);
    repeat (50) @(posedge clk);
    chkv(pw, CF_PULSE_CYC, "pulse length");
    $display("Test reconfigure done");
    tally_and_finish();
  end

  // Watchdog well beyond the expected run
  initial
  begin
    #(20000 * 50);
    err_total++;
    $display("Error %0t: watchdog expired", $time);
    tally_and_finish();
  end
endmodule : testbench
